// file: hdl/ddw_top.sv
// Purpose: channel register map over AXI4-Lite plus the descriptor write master port
// Assumes: one clock aclk, synchronous active-low reset aresetn
// Notes:   map chosen at build time; unmapped offsets answer OKAY, read zero
`timescale 1ns/1ps
module ddw_top #(
	parameter int           CHAIN_MODE_PARAM      = 1,
	parameter logic [31:0]  REGS_BASE_PARAM       = 32'h0000_0000,
	parameter int           DESC_PORT_WIDTH_PARAM = 32,
	parameter int           DESC_ADDR_W           = 32,
	parameter int           REG_ADDR_W            = 32
) (
	input  wire logic                               aclk,
	input  wire logic                               aresetn,
	// AXI4-Lite register slave
	input  wire logic [REG_ADDR_W-1:0]              s_axil_awaddr,
	input  wire logic                               s_axil_awvalid,
	output wire logic                               s_axil_awready,
	input  wire logic [31:0]                        s_axil_wdata,
	input  wire logic [3:0]                         s_axil_wstrb,
	input  wire logic                               s_axil_wvalid,
	output wire logic                               s_axil_wready,
	output logic [1:0]                              s_axil_bresp,
	output logic                                    s_axil_bvalid,
	input  wire logic                               s_axil_bready,
	input  wire logic [REG_ADDR_W-1:0]              s_axil_araddr,
	input  wire logic                               s_axil_arvalid,
	output wire logic                               s_axil_arready,
	output logic [31:0]                             s_axil_rdata,
	output logic [1:0]                              s_axil_rresp,
	output logic                                    s_axil_rvalid,
	input  wire logic                               s_axil_rready,
	// descriptor master port, write side
	output wire logic [DESC_ADDR_W-1:0]             dmp_awaddr,
	output wire logic [7:0]                         dmp_awlen,
	output wire logic [2:0]                         dmp_awsize,
	output wire logic [1:0]                         dmp_awburst,
	output wire logic [2:0]                         dmp_awprot,
	output wire logic [3:0]                         dmp_awcache,
	output wire logic                               dmp_awvalid,
	input  wire logic                               dmp_awready,
	output wire logic [DESC_PORT_WIDTH_PARAM-1:0]   dmp_wdata,
	output wire logic [DESC_PORT_WIDTH_PARAM/8-1:0] dmp_wstrb,
	output wire logic                               dmp_wlast,
	output wire logic                               dmp_wvalid,
	input  wire logic                               dmp_wready,
	input  wire logic [1:0]                         dmp_bresp,
	input  wire logic                               dmp_bvalid,
	output wire logic                               dmp_bready,
	// channel run levels for the data movers
	output wire logic                               tx_run,
	output wire logic                               rx_run
);
	initial begin
		if (CHAIN_MODE_PARAM != 0 && CHAIN_MODE_PARAM != 1)
			$error("ddw_top: mode must be 0 or 1");
		if (DESC_PORT_WIDTH_PARAM != 32 || DESC_ADDR_W > 32 || REG_ADDR_W < ddw_pkg::OFS_BITS)
			$error("ddw_top: unsupported width");
	end

	localparam logic IS_CHAIN = (CHAIN_MODE_PARAM == 1);

	// register storage
	logic [31:0] tx_ctrl_q;
	logic [31:0] rx_ctrl_q;
	logic [31:0] tx_ptr_a_q; // current descriptor or source address
	logic [31:0] tx_ptr_b_q; // last descriptor or byte count
	logic [31:0] rx_ptr_a_q;
	logic [31:0] rx_ptr_b_q;
	logic [31:0] dw_addr_q;
	logic [31:0] dw_data_q;
	logic        dw_err_q;
	logic [1:0]  dw_resp_q;

	// AXI4-Lite write side: address and data latched independently
	logic                  aw_held_q;
	logic                  w_held_q;
	logic [REG_ADDR_W-1:0] aw_addr_q;
	logic [31:0]           w_data_q;
	logic [3:0]            w_strb_q;

	assign s_axil_awready = !aw_held_q && !s_axil_bvalid;
	assign s_axil_wready  = !w_held_q && !s_axil_bvalid;

	wire                  aw_take  = s_axil_awvalid && s_axil_awready;
	wire                  w_take   = s_axil_wvalid && s_axil_wready;
	wire                  aw_have  = aw_held_q || aw_take;
	wire                  w_have   = w_held_q || w_take;
	wire                  wr_do    = aw_have && w_have;
	wire [REG_ADDR_W-1:0] wr_addr  = aw_take ? s_axil_awaddr : aw_addr_q;
	wire [31:0]           wr_data  = w_take ? s_axil_wdata : w_data_q;
	wire [3:0]            wr_strb  = w_take ? s_axil_wstrb : w_strb_q;

	// offset relative to the build-time base; out-of-window falls to reserved
	wire [REG_ADDR_W-1:0] wr_rel   = wr_addr - REG_ADDR_W'(REGS_BASE_PARAM);
	wire [REG_ADDR_W-1:0] rd_rel   = s_axil_araddr - REG_ADDR_W'(REGS_BASE_PARAM);
	wire                  wr_inwin = (wr_rel >> ddw_pkg::OFS_BITS) == '0;
	wire                  rd_inwin = (rd_rel >> ddw_pkg::OFS_BITS) == '0;
	wire [7:0]            wr_ofs   = {wr_rel[7:2], 2'b00};
	wire [7:0]            rd_ofs   = {rd_rel[7:2], 2'b00};

	// byte-lane merge for writes
	wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// write decode: each map answers only its own offsets
	wire wsel_tx_ctrl = wr_do && wr_inwin && wr_ofs == ddw_pkg::TX_CTRL_OFS;
	wire wsel_rx_ctrl = wr_do && wr_inwin && wr_ofs == ddw_pkg::RX_CTRL_OFS;
	wire wsel_tx_a    = wr_do && wr_inwin &&
		(IS_CHAIN ? wr_ofs == ddw_pkg::TX_CURD_OFS : wr_ofs == ddw_pkg::TX_SRC_OFS);
	wire wsel_tx_b    = wr_do && wr_inwin &&
		(IS_CHAIN ? wr_ofs == ddw_pkg::TX_LASTD_OFS : wr_ofs == ddw_pkg::TX_LEN_OFS);
	wire wsel_rx_a    = wr_do && wr_inwin &&
		(IS_CHAIN ? wr_ofs == ddw_pkg::RX_CURD_OFS : wr_ofs == ddw_pkg::RX_DST_OFS);
	wire wsel_rx_b    = wr_do && wr_inwin &&
		(IS_CHAIN ? wr_ofs == ddw_pkg::RX_LASTD_OFS : wr_ofs == ddw_pkg::RX_LEN_OFS);
	wire wsel_dw_addr = wr_do && wr_inwin && wr_ofs == ddw_pkg::DW_ADDR_OFS;
	wire wsel_dw_data = wr_do && wr_inwin && wr_ofs == ddw_pkg::DW_DATA_OFS;
	wire wsel_dw_cmd  = wr_do && wr_inwin && wr_ofs == ddw_pkg::DW_CMD_OFS;
	wire wsel_dw_stat = wr_do && wr_inwin && wr_ofs == ddw_pkg::DW_STAT_OFS;

	// descriptor write engine hookup
	wire       dw_busy;
	wire       dw_done;
	wire [1:0] dw_done_resp;
	wire       dw_start = wsel_dw_cmd && wr_strb[0] && wr_data[0] && !dw_busy;

	ddw_writer #(
		.ADDR_W (DESC_ADDR_W),
		.DATA_W (DESC_PORT_WIDTH_PARAM),
		.LEN_W  (8)
	) u_writer (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.start          (dw_start),
		.start_addr     (dw_addr_q[DESC_ADDR_W-1:0]),
		.start_data     (dw_data_q),
		.start_beats_m1 (8'h00),
		.busy           (dw_busy),
		.done           (dw_done),
		.done_resp      (dw_done_resp),
		.awaddr         (dmp_awaddr),
		.awlen          (dmp_awlen),
		.awsize         (dmp_awsize),
		.awburst        (dmp_awburst),
		.awprot         (dmp_awprot),
		.awcache        (dmp_awcache),
		.awvalid        (dmp_awvalid),
		.awready        (dmp_awready),
		.wdata          (dmp_wdata),
		.wstrb          (dmp_wstrb),
		.wlast          (dmp_wlast),
		.wvalid         (dmp_wvalid),
		.wready         (dmp_wready),
		.bresp          (dmp_bresp),
		.bvalid         (dmp_bvalid),
		.bready         (dmp_bready)
	);

	// write bus handshake and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			aw_addr_q     <= '0;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axil_bvalid <= 1'b0;
			s_axil_bresp  <= ddw_pkg::RESP_OKAY;
		end else begin
			if (aw_take)
				aw_addr_q <= s_axil_awaddr;
			if (w_take) begin
				w_data_q <= s_axil_wdata;
				w_strb_q <= s_axil_wstrb;
			end
			aw_held_q <= aw_have && !wr_do;
			w_held_q  <= w_have && !wr_do;
			if (wr_do) begin
				s_axil_bvalid <= 1'b1;
				s_axil_bresp  <= ddw_pkg::RESP_OKAY; // reserved writes also okay
			end else if (s_axil_bready) begin
				s_axil_bvalid <= 1'b0;
			end
		end
	end

	// register updates; reserved offsets have no select and are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_ctrl_q  <= ddw_pkg::CTRL_RST_VAL;
			rx_ctrl_q  <= ddw_pkg::CTRL_RST_VAL;
			tx_ptr_a_q <= ddw_pkg::REG_RST_VAL;
			tx_ptr_b_q <= ddw_pkg::REG_RST_VAL;
			rx_ptr_a_q <= ddw_pkg::REG_RST_VAL;
			rx_ptr_b_q <= ddw_pkg::REG_RST_VAL;
			dw_addr_q  <= ddw_pkg::REG_RST_VAL;
			dw_data_q  <= ddw_pkg::REG_RST_VAL;
		end else begin
			if (wsel_tx_ctrl)
				tx_ctrl_q <= merge(tx_ctrl_q, wr_data, strb_mask & ddw_pkg::CTRL_WR_MASK);
			if (wsel_rx_ctrl)
				rx_ctrl_q <= merge(rx_ctrl_q, wr_data, strb_mask & ddw_pkg::CTRL_WR_MASK);
			if (wsel_tx_a)
				tx_ptr_a_q <= merge(tx_ptr_a_q, wr_data, strb_mask);
			if (wsel_tx_b)
				tx_ptr_b_q <= merge(tx_ptr_b_q, wr_data, strb_mask);
			if (wsel_rx_a)
				rx_ptr_a_q <= merge(rx_ptr_a_q, wr_data, strb_mask);
			if (wsel_rx_b)
				rx_ptr_b_q <= merge(rx_ptr_b_q, wr_data, strb_mask);
			if (wsel_dw_addr && !dw_busy)
				dw_addr_q <= merge(dw_addr_q, wr_data, strb_mask);
			if (wsel_dw_data && !dw_busy)
				dw_data_q <= merge(dw_data_q, wr_data, strb_mask);
		end
	end

	// sticky error from the write response; a new error beats a clear
	wire dw_bad = dw_done && (dw_done_resp == ddw_pkg::RESP_SLVERR || dw_done_resp == ddw_pkg::RESP_DECERR);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dw_err_q  <= 1'b0;
			dw_resp_q <= ddw_pkg::RESP_OKAY;
		end else begin
			if (dw_done)
				dw_resp_q <= dw_done_resp;
			if (dw_bad)
				dw_err_q <= 1'b1;
			else if (wsel_dw_stat && wr_strb[0] && wr_data[1])
				dw_err_q <= 1'b0;
		end
	end

	assign tx_run = tx_ctrl_q[ddw_pkg::CTRL_RUN_BIT];
	assign rx_run = rx_ctrl_q[ddw_pkg::CTRL_RUN_BIT];

	// status words: halted while not running
	wire [31:0] tx_stat = {31'h0000_0000, !tx_run};
	wire [31:0] rx_stat = {31'h0000_0000, !rx_run};
	// busy covers the done cycle, so a poll never sees idle before the code lands
	wire [31:0] dw_stat = {28'h000_0000, dw_resp_q, dw_err_q, dw_busy || dw_done};

	// read decode; anything unmatched reads zero
	wire rsel_tx_a = IS_CHAIN ? rd_ofs == ddw_pkg::TX_CURD_OFS : rd_ofs == ddw_pkg::TX_SRC_OFS;
	wire rsel_tx_b = IS_CHAIN ? rd_ofs == ddw_pkg::TX_LASTD_OFS : rd_ofs == ddw_pkg::TX_LEN_OFS;
	wire rsel_rx_a = IS_CHAIN ? rd_ofs == ddw_pkg::RX_CURD_OFS : rd_ofs == ddw_pkg::RX_DST_OFS;
	wire rsel_rx_b = IS_CHAIN ? rd_ofs == ddw_pkg::RX_LASTD_OFS : rd_ofs == ddw_pkg::RX_LEN_OFS;
	wire [31:0] rd_word =
		!rd_inwin                          ? 32'h0000_0000 :
		rd_ofs == ddw_pkg::TX_CTRL_OFS     ? tx_ctrl_q :
		rd_ofs == ddw_pkg::TX_STAT_OFS     ? tx_stat :
		rd_ofs == ddw_pkg::RX_CTRL_OFS     ? rx_ctrl_q :
		rd_ofs == ddw_pkg::RX_STAT_OFS     ? rx_stat :
		rsel_tx_a                          ? tx_ptr_a_q :
		rsel_tx_b                          ? tx_ptr_b_q :
		rsel_rx_a                          ? rx_ptr_a_q :
		rsel_rx_b                          ? rx_ptr_b_q :
		rd_ofs == ddw_pkg::DW_ADDR_OFS     ? dw_addr_q :
		rd_ofs == ddw_pkg::DW_DATA_OFS     ? dw_data_q :
		rd_ofs == ddw_pkg::DW_STAT_OFS     ? dw_stat :
		32'h0000_0000;

	// read channel; one read outstanding, arready low while rvalid stands
	assign s_axil_arready = !s_axil_rvalid;
	wire ar_take = s_axil_arvalid && s_axil_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata  <= 32'h0000_0000;
			s_axil_rresp  <= ddw_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				s_axil_rvalid <= 1'b1;
				s_axil_rdata  <= rd_word;
				s_axil_rresp  <= ddw_pkg::RESP_OKAY;
			end else if (s_axil_rready) begin
				s_axil_rvalid <= 1'b0;
			end
		end
	end
endmodule : ddw_top

// file: hdl/ddw_writer.sv
// Purpose: descriptor write master, address, data and response channels
// Assumes: one outstanding burst; beats are 32-bit words
// Notes:   data comes from flip-flops; strobes, prot and cache are constant
`timescale 1ns/1ps
module ddw_writer #(
	parameter int ADDR_W = 32,
	parameter int DATA_W = 32,
	parameter int LEN_W  = 8
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                start,
	input  wire logic [ADDR_W-1:0]   start_addr,
	input  wire logic [DATA_W-1:0]   start_data,
	input  wire logic [LEN_W-1:0]    start_beats_m1,
	output wire logic                busy,
	output logic                     done,
	output logic [1:0]               done_resp,
	output logic [ADDR_W-1:0]        awaddr,
	output wire logic [7:0]          awlen,
	output wire logic [2:0]          awsize,
	output wire logic [1:0]          awburst,
	output wire logic [2:0]          awprot,
	output wire logic [3:0]          awcache,
	output logic                     awvalid,
	input  wire logic                awready,
	output logic [DATA_W-1:0]        wdata,
	output wire logic [DATA_W/8-1:0] wstrb,
	output wire logic                wlast,
	output logic                     wvalid,
	input  wire logic                wready,
	input  wire logic [1:0]          bresp,
	input  wire logic                bvalid,
	output wire logic                bready
);
	initial begin
		if (LEN_W > 8 || DATA_W != 32)
			$error("ddw_writer: unsupported width");
	end

	ddw_pkg::ddw_state_t state_q;
	logic [7:0]          len_q;
	logic [7:0]          beat_q;

	// fixed attributes, constant from reset onward
	assign awprot  = ddw_pkg::AWPROT_VAL;
	assign awcache = ddw_pkg::AWCACHE_VAL;
	assign wstrb   = '1;
	assign awsize  = ddw_pkg::AWSIZE_VAL;
	assign awburst = ddw_pkg::AWBURST_VAL;
	assign awlen   = len_q;                // beats minus one
	assign wlast   = wvalid && (beat_q == len_q);
	assign bready  = (state_q == ddw_pkg::DDW_RESP);
	assign busy    = (state_q != ddw_pkg::DDW_IDLE);

	wire aw_fire = awvalid && awready;
	wire w_fire  = wvalid && wready;
	wire b_fire  = bvalid && bready;
	wire w_end   = w_fire && (beat_q == len_q);

	// burst sequencer; address and data may be taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= ddw_pkg::DDW_IDLE;
			awvalid   <= 1'b0;
			wvalid    <= 1'b0;
			awaddr    <= '0;
			wdata     <= '0;
			len_q     <= 8'h00;
			beat_q    <= 8'h00;
			done      <= 1'b0;
			done_resp <= ddw_pkg::RESP_OKAY;
		end else begin
			done <= 1'b0;
			unique case (state_q)
				ddw_pkg::DDW_IDLE: begin
					if (start) begin
						awaddr  <= start_addr;
						wdata   <= start_data;
						len_q   <= 8'(start_beats_m1);
						beat_q  <= 8'h00;
						awvalid <= 1'b1;
						wvalid  <= 1'b1;
						state_q <= ddw_pkg::DDW_SEND;
					end
				end
				ddw_pkg::DDW_SEND: begin
					if (aw_fire)
						awvalid <= 1'b0;
					if (w_fire)
						beat_q <= beat_q + 8'h01;
					if (w_end)
						wvalid <= 1'b0;
					if ((w_end || !wvalid) && (aw_fire || !awvalid))
						state_q <= ddw_pkg::DDW_RESP;
				end
				ddw_pkg::DDW_RESP: begin
					if (b_fire) begin
						// exclusive okay is never expected: no exclusive access issued
						done_resp <= (bresp == ddw_pkg::RESP_EXOKAY) ? ddw_pkg::RESP_SLVERR : bresp;
						done      <= 1'b1;
						state_q   <= ddw_pkg::DDW_IDLE;
					end
				end
			endcase
		end
	end
endmodule : ddw_writer

// file: include/ddw_pkg.sv
// Purpose: shared constants for the descriptor write port and the channel register map
// Assumes: 32-bit AXI4-Lite register bus, byte offsets relative to a build-time base
// Notes:   every offset, reset value and fixed attribute lives here once
package ddw_pkg;
	// register byte offsets, both maps
	localparam logic [7:0] TX_CTRL_OFS  = 8'h00;
	localparam logic [7:0] TX_STAT_OFS  = 8'h04;
	localparam logic [7:0] TX_CURD_OFS  = 8'h08;
	localparam logic [7:0] TX_LASTD_OFS = 8'h10;
	localparam logic [7:0] TX_SRC_OFS   = 8'h18;
	localparam logic [7:0] TX_LEN_OFS   = 8'h28;
	localparam logic [7:0] RX_CTRL_OFS  = 8'h30;
	localparam logic [7:0] RX_STAT_OFS  = 8'h34;
	localparam logic [7:0] RX_CURD_OFS  = 8'h38;
	localparam logic [7:0] RX_LASTD_OFS = 8'h40;
	localparam logic [7:0] RX_DST_OFS   = 8'h48;
	localparam logic [7:0] RX_LEN_OFS   = 8'h58;
	// own: descriptor write request registers
	localparam logic [7:0] DW_ADDR_OFS  = 8'h60;
	localparam logic [7:0] DW_DATA_OFS  = 8'h64;
	localparam logic [7:0] DW_CMD_OFS   = 8'h68;
	localparam logic [7:0] DW_STAT_OFS  = 8'h6C;
	localparam int         OFS_BITS     = 8;
	// control and status fields
	localparam int         CTRL_RUN_BIT  = 0;
	localparam int         CTRL_ONE_BIT  = 1;
	localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0002;
	localparam logic [31:0] CTRL_WR_MASK = 32'hFFFF_F001;
	localparam int         STAT_HALT_BIT = 0;
	localparam logic [31:0] REG_RST_VAL  = 32'h0000_0000;
	// fixed write attributes
	localparam logic [2:0] AWPROT_VAL  = 3'h2;
	localparam logic [3:0] AWCACHE_VAL = 4'h3;
	localparam logic [2:0] AWSIZE_VAL  = 3'h2;
	localparam logic [1:0] AWBURST_VAL = 2'h1;
	// write response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_EXOKAY = 2'h1;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// write master states, gray from idle to send to resp; the return from resp to idle flips both bits
	typedef enum logic [1:0] {
		DDW_IDLE = 2'b00,
		DDW_SEND = 2'b01,
		DDW_RESP = 2'b11
	} ddw_state_t;
endpackage : ddw_pkg

// file: testbench/ddw_assertions.sv
// Purpose: timing checks on the descriptor write port
// Assumes: one clock aclk, synchronous active-low aresetn
// Notes:   sees top-level ports only, attached by bind
`timescale 1ns/1ps
module ddw_assertions #(
	parameter int DESC_PORT_WIDTH_PARAM = 32,
	parameter int DESC_ADDR_W           = 32
) (
	input wire logic                               aclk,
	input wire logic                               aresetn,
	input wire logic [DESC_ADDR_W-1:0]             dmp_awaddr,
	input wire logic [7:0]                         dmp_awlen,
	input wire logic [2:0]                         dmp_awsize,
	input wire logic [1:0]                         dmp_awburst,
	input wire logic [2:0]                         dmp_awprot,
	input wire logic [3:0]                         dmp_awcache,
	input wire logic                               dmp_awvalid,
	input wire logic                               dmp_awready,
	input wire logic [DESC_PORT_WIDTH_PARAM-1:0]   dmp_wdata,
	input wire logic [DESC_PORT_WIDTH_PARAM/8-1:0] dmp_wstrb,
	input wire logic                               dmp_wlast,
	input wire logic                               dmp_wvalid,
	input wire logic                               dmp_wready,
	input wire logic                               dmp_bvalid,
	input wire logic                               dmp_bready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// fixed attributes: prot and cache checked on every cycle, strobes only while wvalid
	property p_prot; dmp_awprot == 3'h2; endproperty
	a_prot: assert property (p_prot) else $error("awprot not fixed");
	property p_cache; dmp_awcache == 4'h3; endproperty
	a_cache: assert property (p_cache) else $error("awcache not fixed");
	property p_aw_hold; dmp_awvalid && !dmp_awready |=> dmp_awvalid && $stable(dmp_awaddr); endproperty
	a_aw_hold: assert property (p_aw_hold) else $error("address dropped early");
	property p_strb; dmp_wvalid |-> &dmp_wstrb; endproperty
	a_strb: assert property (p_strb) else $error("strobe lane low");
	// every burst is one beat, so last follows valid exactly
	property p_last; dmp_wlast == dmp_wvalid; endproperty
	a_last: assert property (p_last) else $error("last misplaced");
	property p_w_hold; dmp_wvalid && !dmp_wready |=> dmp_wvalid && $stable(dmp_wdata); endproperty
	a_w_hold: assert property (p_w_hold) else $error("data dropped early");
	property p_bready; dmp_bvalid && dmp_bready |=> !dmp_bready; endproperty
	a_bready: assert property (p_bready) else $error("bready stuck after response");
	property p_beat; dmp_awvalid |-> dmp_awsize == 3'h2 && dmp_awburst == 2'h1 && dmp_awlen == 8'h00; endproperty
	a_beat: assert property (p_beat) else $error("burst shape wrong");
	property p_rst; $rose(aresetn) |-> !dmp_awvalid && !dmp_wvalid && !dmp_bready && dmp_wdata == '0; endproperty
	a_rst: assert property (p_rst) else $error("port not idle after reset");
endmodule : ddw_assertions

bind ddw_top ddw_assertions #(.DESC_PORT_WIDTH_PARAM(DESC_PORT_WIDTH_PARAM), .DESC_ADDR_W(DESC_ADDR_W))
	u_ddw_assertions (.aclk(aclk), .aresetn(aresetn), .dmp_awaddr(dmp_awaddr), .dmp_awlen(dmp_awlen),
	.dmp_awsize(dmp_awsize), .dmp_awburst(dmp_awburst), .dmp_awprot(dmp_awprot), .dmp_awcache(dmp_awcache),
	.dmp_awvalid(dmp_awvalid), .dmp_awready(dmp_awready), .dmp_wdata(dmp_wdata), .dmp_wstrb(dmp_wstrb),
	.dmp_wlast(dmp_wlast), .dmp_wvalid(dmp_wvalid), .dmp_wready(dmp_wready), .dmp_bvalid(dmp_bvalid),
	.dmp_bready(dmp_bready));

// file: testbench/ddw_mem_model.sv
// Purpose: descriptor memory target on the write port
// Assumes: one burst under way at a time
// Notes:   a released bresp shows the inverse of the last code
`timescale 1ns/1ps
module ddw_mem_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [3:0] stall,
	input  wire logic [1:0] resp,
	input  wire logic       awvalid,
	output logic            awready,
	input  wire logic       wvalid,
	output logic            wready,
	output logic [1:0]      bresp,
	output logic            bvalid,
	input  wire logic       bready
);
	logic [3:0] wait_q;
	logic       got_a_q;
	logic       got_w_q;
	// readies come after the stall count, so slow targets are exercised
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{awready, wready, bvalid, got_a_q, got_w_q} <= 5'h00;
			wait_q <= 4'h0;
			bresp  <= 2'h3;
		end else begin
			wait_q  <= (awvalid || wvalid) ? wait_q + 4'h1 : 4'h0;
			awready <= awvalid && !awready && wait_q >= stall;
			wready  <= wvalid && !wready && wait_q >= stall;
			if (awvalid && awready) got_a_q <= 1'b1;
			if (wvalid && wready) got_w_q <= 1'b1;
			if (got_a_q && got_w_q && !bvalid) begin
				bvalid  <= 1'b1;
				bresp   <= resp;
				got_a_q <= 1'b0;
				got_w_q <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				bresp  <= ~bresp; // no stale code after release
			end
		end
	end
endmodule : ddw_mem_model

// file: testbench/ddw_top_tb.sv
// Purpose: bench for the register map and descriptor write port
// Assumes: both maps, base 0x1000, aclk at 25 MHz
// Notes:   every bus wait is bounded and counts as a mismatch when it runs out
`timescale 1ns/1ps
module ddw_top_tb;
	localparam logic [31:0] BASE = 32'h0000_1000; // word-aligned base
	localparam logic [31:0] OFS [14] = '{32'h08, 32'h10, 32'h38, 32'h40, 32'h00, 32'h30, 32'h0C,
		32'h14, 32'h18, 32'h28, 32'h2C, 32'h3C, 32'h48, 32'h58};
	localparam logic [31:0] EXP [14] = '{32'h8765_4320, 32'h8765_4340, 32'h8765_4360, 32'h8765_4380,
		32'hFFFF_F003, 32'hFFFF_F003, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	localparam logic [31:0] EXP_S [14] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF_F003, 32'hFFFF_F003,
		32'h0, 32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
	localparam logic [1:0] CODES [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, tx_run, rx_run;
	logic [31:0] awaddr, wdata, araddr, rdata, d_awaddr, d_wdata, cap_a, cap_d, rd_q, rdata_s, rd_s;
	logic [3:0]  wstrb, stall, d_awcache, d_wstrb;
	logic [1:0]  bresp, rresp, resp, m_bresp, d_awburst;
	logic [2:0]  d_awsize, d_awprot;
	logic [7:0]  d_awlen, cap_l;
	logic        d_awvalid, d_awready, d_wlast, d_wvalid, d_wready, d_bvalid, d_bready;
	int          mismatches, checks_done, i, n;

	ddw_top #(.REGS_BASE_PARAM(BASE)) u_ddw_top (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
		.s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
		.s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
		.s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
		.dmp_awaddr(d_awaddr), .dmp_awlen(d_awlen), .dmp_awsize(d_awsize), .dmp_awburst(d_awburst),
		.dmp_awprot(d_awprot), .dmp_awcache(d_awcache), .dmp_awvalid(d_awvalid), .dmp_awready(d_awready),
		.dmp_wdata(d_wdata), .dmp_wstrb(d_wstrb), .dmp_wlast(d_wlast), .dmp_wvalid(d_wvalid),
		.dmp_wready(d_wready), .dmp_bresp(m_bresp), .dmp_bvalid(d_bvalid), .dmp_bready(d_bready),
		.tx_run(tx_run), .rx_run(rx_run));
	// simple map twin on the same bus; it answers in step with the chain map instance
	ddw_top #(.CHAIN_MODE_PARAM(0), .REGS_BASE_PARAM(BASE)) u_ddw_top_simple (.aclk(aclk), .aresetn(aresetn),
		.s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(), .s_axil_wdata(wdata),
		.s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(), .s_axil_bresp(), .s_axil_bvalid(),
		.s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(),
		.s_axil_rdata(rdata_s), .s_axil_rresp(), .s_axil_rvalid(), .s_axil_rready(rready), .dmp_awaddr(),
		.dmp_awlen(), .dmp_awsize(), .dmp_awburst(), .dmp_awprot(), .dmp_awcache(), .dmp_awvalid(),
		.dmp_awready(d_awready), .dmp_wdata(), .dmp_wstrb(), .dmp_wlast(), .dmp_wvalid(), .dmp_wready(d_wready),
		.dmp_bresp(m_bresp), .dmp_bvalid(d_bvalid), .dmp_bready(), .tx_run(), .rx_run());
	ddw_mem_model u_ddw_mem_model (.aclk(aclk), .aresetn(aresetn), .stall(stall), .resp(resp),
		.awvalid(d_awvalid), .awready(d_awready), .wvalid(d_wvalid), .wready(d_wready),
		.bresp(m_bresp), .bvalid(d_bvalid), .bready(d_bready));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// snapshot of what the target accepted
	always @(posedge aclk) begin
		if (d_awvalid && d_awready) {cap_a, cap_l} <= {d_awaddr, d_awlen};
		if (d_wvalid && d_wready) cap_d <= d_wdata;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic hung();
		mismatches++;
		$display("[FAIL] handshake expected answer seen timeout");
		complete_run();
	endtask : hung
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge aclk);
		{awaddr, wdata} <= {BASE + a, d};
		{awvalid, wvalid, bready} <= 3'b111;
		for (k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (k == 40) hung();
		chk("bresp", 32'h0, {30'h0, bresp});
	endtask : wr
	task automatic rd(input logic [31:0] a);
		int k;
		@(posedge aclk);
		araddr <= BASE + a;
		{arvalid, rready} <= 2'b11;
		for (k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		{rd_q, rd_s} = {rdata, rdata_s};
		if (k == 40) hung();
		chk("rresp", 32'h0, {30'h0, rresp});
	endtask : rd
	task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
		rd(a);
		chk(what, exp, rd_q);
	endtask : rdc
	task automatic complete_run();
		if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, wdata, araddr, resp, stall, wstrb} = {96'h0, 2'h0, 4'h0, 4'hF};
		repeat (10) @(posedge aclk);
		chk("port idle", {4'h0, 3'h2, 4'h3, 4'hF}, {d_awvalid, d_wvalid, d_wlast, d_bready,
			d_awprot, d_awcache, d_wstrb});
		chk("wdata rst", 32'h0, d_wdata);
		aresetn <= 1'b1;
		rdc("tx ctrl rst", 32'h00, 32'h2);
		rdc("rx stat rst", 32'h34, 32'h1);
		// full map: pointers and control hold, reserved and simple-map places stay zero
		for (i = 0; i < 14; i++) wr(OFS[i], i < 4 ? EXP[i] : 32'hFFFF_FFFF);
		for (i = 0; i < 14; i++) begin
			rdc("map", OFS[i], EXP[i]);
			chk("simple map", EXP_S[i], rd_s);
		end
		chk("run levels", 32'h3, {30'h0, tx_run, rx_run});
		rdc("tx stat run", 32'h04, 32'h0);
		wr(32'h108, 32'h0);
		wr(32'hFFFF_FFF8, 32'h0);
		rdc("window", 32'h08, EXP[0]);
		rdc("beyond", 32'h108, 32'h0);
		// one descriptor write per response code, the target stalling longer each time
		for (i = 0; i < 4; i++) begin
			resp <= CODES[i];
			stall <= 4'(i * 3);
			wr(32'h60, 32'h0000_2000 + 32'(i * 16));
			wr(32'h64, 32'hC0DE_0000 + 32'(i));
			wr(32'h6C, 32'h2);
			wr(32'h68, 32'h1);
			for (n = 0; n < 20; n++) begin
				rd(32'h6C);
				if (rd_q[0] === 1'b0) break;
			end
			if (n == 20) hung();
			chk("desc addr", 32'h0000_2000 + 32'(i * 16), cap_a);
			chk("desc data", 32'hC0DE_0000 + 32'(i), cap_d);
			chk("desc len", 32'h0, {24'h0, cap_l});
			chk("desc stat", {28'h0, (CODES[i] == 2'h1 ? 2'h2 : CODES[i]), CODES[i] != 2'h0, 1'b0}, rd_q);
		end
		complete_run();
	end
endmodule : ddw_top_tb
